// File: include/pbed_dt_if.sv
// Link between the bridge control logic and one delayed transaction slot.
// Assumes one instance per direction, driven in the bridge clock domain.
`default_nettype none

interface pbed_dt_if;
  logic req_valid;
  logic [31:0] req_addr;
  logic [3:0] req_cmd;
  logic [3:0] req_be;
  logic req_pref;
  logic capture;
  logic take;
  logic dest_done;
  logic [31:0] dest_data;
  logic dest_abort;
  logic short_per;
  logic busy;
  logic held;
  logic match;
  logic [31:0] cap_addr;
  logic [3:0] cap_cmd;
  logic [3:0] cap_be;
  logic [31:0] data;
  logic abort;
  logic discard;

  modport ctrl(output req_valid, req_addr, req_cmd, req_be, req_pref, capture, take,
    dest_done, dest_data, dest_abort, short_per,
    input busy, held, match, cap_addr, cap_cmd, cap_be, data, abort, discard);
  modport txn(input req_valid, req_addr, req_cmd, req_be, req_pref, capture, take,
    dest_done, dest_data, dest_abort, short_per,
    output busy, held, match, cap_addr, cap_cmd, cap_be, data, abort, discard);
endinterface

`default_nettype wire

// File: include/pbed_pkg.sv
// Types shared by the bridge error block and its delayed transaction slots.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package pbed_pkg;
  typedef enum logic [1:0] {
    DT_IDLE = 2'h0,
    DT_FETCH = 2'h1,
    DT_HELD = 2'h2
  } pbed_dt_state_e;

  typedef enum logic [2:0] {
    RSP_NONE = 3'h0,
    RSP_RETRY = 3'h1,
    RSP_DONE = 3'h2,
    RSP_TABORT = 3'h3,
    RSP_DISC = 3'h4
  } pbed_rsp_e;
endpackage

`default_nettype wire

// File: include/pbed_regs.svh
// Register map, field positions, reset values and timing counts of the
// bridge error and delayed transaction block.
// Assumes byte addresses on a 12-bit APB address, four times each index.
`ifndef PBED_REGS_SVH
`define PBED_REGS_SVH

`define PBED_IDX_CMD 10'h004
`define PBED_IDX_STS 10'h006
`define PBED_IDX_SST 10'h01E
`define PBED_IDX_BC 10'h03E
`define PBED_IDX_DG 10'h05C
`define PBED_IDX_MASK 10'h064
`define PBED_IDX_FLAG 10'h06A
`define PBED_IDX_DTS 10'h080
`define PBED_ADR(i) {i, 2'h0}

`define PBED_CMD_PER 6
`define PBED_CMD_SERR 8
`define PBED_STS_DPD 8
`define PBED_STS_DPE 15
`define PBED_STS_W1C 16'h8100
`define PBED_SST_SERR 14
`define PBED_SST_W1C 16'h4000
`define PBED_BC_FWD 1
`define PBED_BC_MAM 5
`define PBED_BC_DISC 9
`define PBED_DG_DLY 2
`define PBED_DG_PGEN 14
`define PBED_RST16 16'h0000
`define PBED_RST8 8'h00

`define PBED_CMD_MRM 4'hC
`define PBED_CMD_MRL 4'hE
`define PBED_RETRY_DLY 5'h10
`define PBED_DISC_SHORT 16'h0400
`define PBED_DISC_LONG 16'h8000

`endif

// File: rtl/pbed_bridge_err.sv
// Bridge error reporting, parity handling and delayed transaction control.
// Assumes one PCI clock, bus events as one-cycle synchronous pulses,
// software on APB, and at most one target request presented per cycle.
`include "pbed_regs.svh"
`default_nettype none

module pbed_bridge_err #(
  parameter logic [15:0] DISCARD_LONG_CLKS = `PBED_DISC_LONG
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic TGT_REQ,
  input wire logic TGT_DIR,
  input wire logic [31:0] TGT_ADDR,
  input wire logic [3:0] TGT_CMD,
  input wire logic [3:0] TGT_BE,
  input wire logic TGT_PREFETCH,
  output logic TGT_RESP_VLD,
  output logic [2:0] TGT_RESP,
  output logic [31:0] TGT_RDATA,
  output logic DEST_REQ,
  output logic DEST_DIR,
  output logic [31:0] DEST_ADDR,
  output logic [3:0] DEST_CMD,
  output logic [3:0] DEST_BE,
  input wire logic DEST_DONE,
  input wire logic [31:0] DEST_RDATA,
  input wire logic DEST_TABORT,
  input wire logic EV_PW_PERR,
  input wire logic EV_PW_RETRY_TO,
  input wire logic EV_PW_TABORT,
  input wire logic EV_PW_MABORT,
  input wire logic EV_DW_RETRY_TO,
  input wire logic EV_DR_RETRY_TO,
  input wire logic SEC_SERR,
  input wire logic ADDR_PERR,
  input wire logic TABORT_RCVD,
  input wire logic DATA_PERR,
  input wire logic MSTR_PERR,
  input wire logic SEC_RST_ACT,
  output logic PRIMARY_SYSTEM_ERROR_REPORT,
  output logic PERR_OUT,
  output logic PARITY_PASS
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Set wins over a software clear in the same cycle
  function automatic logic [15:0] w1c(input logic [15:0] old, input logic [15:0] clr,
    input logic [15:0] set);
    w1c = (old & ~clr) | set;
  endfunction

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q, rd_mux;
  logic apb_acc, apb_wr, hit_any;
  logic hit_cmd, hit_sts, hit_sst, hit_bc, hit_dg, hit_mask, hit_flag, hit_dts;
  logic [15:0] cmd_q, sts_q, sst_q, bc_q, dg_q;
  logic [7:0] mask_q, flag_q;
  logic [3:0] dts_w;

  // One wait state so every bus output leaves a flip-flop
  assign apb_acc = PSEL && PENABLE && !pready_q;
  assign apb_wr = PSEL && PENABLE && pready_q && PWRITE;
  assign hit_cmd = PADDR == `PBED_ADR(`PBED_IDX_CMD);
  assign hit_sts = PADDR == `PBED_ADR(`PBED_IDX_STS);
  assign hit_sst = PADDR == `PBED_ADR(`PBED_IDX_SST);
  assign hit_bc = PADDR == `PBED_ADR(`PBED_IDX_BC);
  assign hit_dg = PADDR == `PBED_ADR(`PBED_IDX_DG);
  assign hit_mask = PADDR == `PBED_ADR(`PBED_IDX_MASK);
  assign hit_flag = PADDR == `PBED_ADR(`PBED_IDX_FLAG);
  assign hit_dts = PADDR == `PBED_ADR(`PBED_IDX_DTS);
  assign hit_any = hit_cmd || hit_sts || hit_sst || hit_bc || hit_dg || hit_mask || hit_flag || hit_dts;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_cmd) begin
      rd_mux[15:0] = cmd_q;
    end else if (hit_sts) begin
      rd_mux[15:0] = sts_q;
    end else if (hit_sst) begin
      rd_mux[15:0] = sst_q;
    end else if (hit_bc) begin
      rd_mux[15:0] = bc_q;
    end else if (hit_dg) begin
      rd_mux[15:0] = dg_q;
    end else if (hit_mask) begin
      rd_mux[7:0] = mask_q;
    end else if (hit_flag) begin
      rd_mux[7:0] = flag_q;
    end else if (hit_dts) begin
      rd_mux[3:0] = dts_w;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= apb_acc;
      pslverr_q <= apb_acc && !hit_any;
      prdata_q <= apb_acc ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Error events
  // ----------------------------------------
  logic [7:0] ev_vec, flag_set;
  logic par_serr, fwd_serr, serr_fire;
  logic [15:0] sts_set, sst_set;

  assign ev_vec = {1'b0, EV_DR_RETRY_TO, EV_DW_RETRY_TO, EV_PW_MABORT, EV_PW_TABORT,
    EV_PW_RETRY_TO, EV_PW_PERR, 1'b0};
  assign flag_set = ev_vec & ~mask_q;
  assign par_serr = cmd_q[`PBED_CMD_PER] && (ADDR_PERR || TABORT_RCVD);
  assign fwd_serr = bc_q[`PBED_BC_FWD] && SEC_SERR;
  assign serr_fire = cmd_q[`PBED_CMD_SERR] && ((|flag_set) || par_serr || fwd_serr);

  always_comb begin
    sts_set = 16'h0000;
    sts_set[`PBED_STS_DPE] = DATA_PERR || ADDR_PERR;
    sts_set[`PBED_STS_DPD] = cmd_q[`PBED_CMD_PER] && (DATA_PERR || MSTR_PERR);
    sst_set = 16'h0000;
    sst_set[`PBED_SST_SERR] = serr_fire;
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      cmd_q <= `PBED_RST16;
      bc_q <= `PBED_RST16;
      dg_q <= `PBED_RST16;
      mask_q <= `PBED_RST8;
    end else if (apb_wr) begin
      if (hit_cmd) cmd_q <= PWDATA[15:0];
      if (hit_bc) bc_q <= PWDATA[15:0];
      if (hit_dg) dg_q <= PWDATA[15:0];
      if (hit_mask) mask_q <= PWDATA[7:0];
    end
  end

  logic [15:0] sts_clr, sst_clr, flag_clr, flag_nx;

  assign sts_clr = (apb_wr && hit_sts) ? (PWDATA[15:0] & `PBED_STS_W1C) : 16'h0000;
  assign sst_clr = (apb_wr && hit_sst) ? (PWDATA[15:0] & `PBED_SST_W1C) : 16'h0000;
  assign flag_clr = (apb_wr && hit_flag) ? {8'h00, PWDATA[7:0]} : 16'h0000;
  assign flag_nx = w1c({8'h00, flag_q}, flag_clr, {8'h00, flag_set});

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      sts_q <= `PBED_RST16;
      sst_q <= `PBED_RST16;
      flag_q <= `PBED_RST8;
    end else begin
      sts_q <= w1c(sts_q, sts_clr, sts_set);
      sst_q <= w1c(sst_q, sst_clr, sst_set);
      flag_q <= flag_nx[7:0];
    end
  end

  // ----------------------------------------
  // Error and parity outputs
  // ----------------------------------------
  logic serr_q, perr_q, ppass_q;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      serr_q <= 1'b0;
      perr_q <= 1'b0;
      ppass_q <= 1'b1;
    end else begin
      serr_q <= serr_fire;
      perr_q <= cmd_q[`PBED_CMD_PER] && DATA_PERR;
      ppass_q <= !dg_q[`PBED_DG_PGEN];
    end
  end

  // ----------------------------------------
  // Delayed transaction slots, one per direction
  // ----------------------------------------
  pbed_dt_if dt [2] ();
  logic [1:0] busy_w, held_w, match_w, abort_w, pend_w, hit_dir;
  logic [31:0] data_w [2];
  logic [31:0] caddr_w [2];
  logic [3:0] ccmd_w [2];
  logic [3:0] cbe_w [2];
  logic wait_q, sec_block, dreq_q, dsel_q;

  // Downstream requests come from the primary side; block them in secondary reset
  assign sec_block = SEC_RST_ACT && !TGT_DIR;

  for (genvar g = 0; g < 2; g++) begin : g_dt
    assign hit_dir[g] = TGT_REQ && (TGT_DIR == 1'(g)) && !wait_q && !sec_block;
    assign dt[g].req_valid = hit_dir[g];
    assign dt[g].req_addr = TGT_ADDR;
    assign dt[g].req_cmd = TGT_CMD;
    assign dt[g].req_be = TGT_BE;
    assign dt[g].req_pref = TGT_PREFETCH;
    assign dt[g].capture = hit_dir[g] && !busy_w[g];
    assign dt[g].take = hit_dir[g] && match_w[g];
    assign dt[g].dest_done = DEST_DONE && dreq_q && (dsel_q == 1'(g));
    assign dt[g].dest_data = DEST_RDATA;
    assign dt[g].dest_abort = DEST_TABORT;
    assign dt[g].short_per = bc_q[`PBED_BC_DISC];
    assign busy_w[g] = dt[g].busy;
    assign held_w[g] = dt[g].held;
    assign match_w[g] = dt[g].match;
    assign abort_w[g] = dt[g].abort;
    assign data_w[g] = dt[g].data;
    assign caddr_w[g] = dt[g].cap_addr;
    assign ccmd_w[g] = dt[g].cap_cmd;
    assign cbe_w[g] = dt[g].cap_be;
    assign pend_w[g] = busy_w[g] && !held_w[g];

    pbed_dtxn #(
      .LONG_CLKS(DISCARD_LONG_CLKS)
    ) u_dtxn (
      .clk(SYS_CLK),
      .rst(RST),
      .dt(dt[g])
    );
  end

  assign dts_w = {held_w[1], busy_w[1], held_w[0], busy_w[0]};

  // ----------------------------------------
  // Target answer
  // ----------------------------------------
  logic [4:0] wait_cnt_q;
  logic vld_q, vld_d, start_wait;
  logic [2:0] rsp_q;
  pbed_pkg::pbed_rsp_e rsp_d;
  logic [31:0] rdata_q, rdata_d;
  logic m_sel, a_sel, wr_sel;
  logic [31:0] d_sel;

  assign m_sel = TGT_DIR ? match_w[1] : match_w[0];
  assign a_sel = TGT_DIR ? abort_w[1] : abort_w[0];
  assign d_sel = TGT_DIR ? data_w[1] : data_w[0];
  assign wr_sel = TGT_DIR ? ccmd_w[1][0] : ccmd_w[0][0];

  always_comb begin
    vld_d = 1'b0;
    rsp_d = pbed_pkg::RSP_NONE;
    rdata_d = 32'h0000_0000;
    start_wait = 1'b0;
    if (wait_q) begin
      if (wait_cnt_q == 5'h00) begin
        vld_d = 1'b1;
        rsp_d = pbed_pkg::RSP_RETRY;
      end
    end else if (TGT_REQ) begin
      vld_d = 1'b1;
      if (sec_block) begin
        rsp_d = bc_q[`PBED_BC_MAM] ? pbed_pkg::RSP_TABORT : pbed_pkg::RSP_NONE;
      end else if (m_sel) begin
        if (!a_sel) begin
          rsp_d = pbed_pkg::RSP_DONE;
          rdata_d = wr_sel ? 32'h0000_0000 : d_sel;
        end else if (wr_sel) begin
          rsp_d = pbed_pkg::RSP_TABORT;
        end else begin
          rsp_d = pbed_pkg::RSP_DISC;
          rdata_d = d_sel;
        end
      end else if (dg_q[`PBED_DG_DLY]) begin
        vld_d = 1'b0;
        start_wait = 1'b1;
      end else begin
        rsp_d = pbed_pkg::RSP_RETRY;
      end
    end
  end

  // Retry waits hold off further requests until the answer goes out
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      wait_q <= 1'b0;
      wait_cnt_q <= 5'h00;
    end else if (start_wait) begin
      wait_q <= 1'b1;
      wait_cnt_q <= `PBED_RETRY_DLY - 5'h02;
    end else if (wait_q) begin
      wait_q <= wait_cnt_q != 5'h00;
      wait_cnt_q <= wait_cnt_q - 5'h01;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      vld_q <= 1'b0;
      rsp_q <= 3'h0;
      rdata_q <= 32'h0000_0000;
    end else begin
      vld_q <= vld_d;
      rsp_q <= rsp_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------
  // Destination request
  // ----------------------------------------
  logic [31:0] daddr_q;
  logic [3:0] dcmd_q, dbe_q;
  logic pick;

  // Downstream wins when both slots wait for the destination
  assign pick = !pend_w[0];

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      dreq_q <= 1'b0;
      dsel_q <= 1'b0;
      daddr_q <= 32'h0000_0000;
      dcmd_q <= 4'h0;
      dbe_q <= 4'h0;
    end else if (!dreq_q) begin
      if (|pend_w) begin
        dreq_q <= 1'b1;
        dsel_q <= pick;
        daddr_q <= pick ? caddr_w[1] : caddr_w[0];
        dcmd_q <= pick ? ccmd_w[1] : ccmd_w[0];
        dbe_q <= pick ? cbe_w[1] : cbe_w[0];
      end
    end else if (DEST_DONE) begin
      dreq_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign TGT_RESP_VLD = vld_q;
  assign TGT_RESP = rsp_q;
  assign TGT_RDATA = rdata_q;
  assign DEST_REQ = dreq_q;
  assign DEST_DIR = dsel_q;
  assign DEST_ADDR = daddr_q;
  assign DEST_CMD = dcmd_q;
  assign DEST_BE = dbe_q;
  assign PRIMARY_SYSTEM_ERROR_REPORT = serr_q;
  assign PERR_OUT = perr_q;
  assign PARITY_PASS = ppass_q;
endmodule

`default_nettype wire

// File: rtl/pbed_dtxn.sv
// One delayed transaction slot: capture, destination completion, match, discard.
// Assumes the control logic captures only while the slot is idle.
`include "pbed_regs.svh"
`default_nettype none

module pbed_dtxn #(
  parameter logic [15:0] LONG_CLKS = `PBED_DISC_LONG
) (
  input wire logic clk,
  input wire logic rst,
  pbed_dt_if.txn dt
);
  pbed_pkg::pbed_dt_state_e state_q, state_d;
  logic [31:0] addr_q, data_q;
  logic [3:0] cmd_q, be_q;
  logic abort_q, short_q, discard_q, expire;
  logic [15:0] tmr_q, period;

  assign period = short_q ? `PBED_DISC_SHORT : LONG_CLKS;
  assign expire = (state_q == pbed_pkg::DT_HELD) && (tmr_q == period - 16'h0001);
  assign dt.match = dt.req_valid && (state_q == pbed_pkg::DT_HELD) && (dt.req_addr == addr_q) &&
    (dt.req_cmd == cmd_q) && (dt.req_be == be_q);

  always_comb begin
    state_d = state_q;
    case (state_q)
      pbed_pkg::DT_IDLE: if (dt.capture) state_d = pbed_pkg::DT_FETCH;
      pbed_pkg::DT_FETCH: if (dt.dest_done) state_d = pbed_pkg::DT_HELD;
      pbed_pkg::DT_HELD: if (dt.take || expire) state_d = pbed_pkg::DT_IDLE;
      default: state_d = pbed_pkg::DT_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= pbed_pkg::DT_IDLE;
      tmr_q <= 16'h0000;
      discard_q <= 1'b0;
    end else begin
      state_q <= state_d;
      tmr_q <= (state_q == pbed_pkg::DT_HELD) ? tmr_q + 16'h0001 : 16'h0000;
      discard_q <= expire && !dt.take;
    end
  end

  // Captured fields and completion only load on their events
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_q <= 32'h0000_0000;
      cmd_q <= 4'h0;
      be_q <= 4'h0;
      short_q <= 1'b0;
      data_q <= 32'h0000_0000;
      abort_q <= 1'b0;
    end else if (dt.capture && state_q == pbed_pkg::DT_IDLE) begin
      addr_q <= dt.req_addr;
      cmd_q <= dt.req_cmd;
      be_q <= dt.req_be;
      short_q <= dt.short_per || (!dt.req_cmd[0] && (dt.req_pref || dt.req_cmd == `PBED_CMD_MRM ||
        dt.req_cmd == `PBED_CMD_MRL));
    end else if (dt.dest_done && state_q == pbed_pkg::DT_FETCH) begin
      data_q <= dt.dest_data;
      abort_q <= dt.dest_abort;
    end
  end

  assign dt.busy = state_q != pbed_pkg::DT_IDLE;
  assign dt.held = state_q == pbed_pkg::DT_HELD;
  assign dt.cap_addr = addr_q;
  assign dt.cap_cmd = cmd_q;
  assign dt.cap_be = be_q;
  assign dt.data = data_q;
  assign dt.abort = abort_q;
  assign dt.discard = discard_q;
endmodule

`default_nettype wire

// File: verification/pbed_bridge_err_sva.sv
// Checker of the bridge error block, seen from the top ports only.
// Assumes register shadows that follow APB writes landing with PREADY.
`default_nettype none

module pbed_bridge_err_sva (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic TGT_REQ,
  input wire logic TGT_DIR,
  input wire logic TGT_RESP_VLD,
  input wire logic [2:0] TGT_RESP,
  input wire logic DEST_REQ,
  input wire logic [31:0] DEST_ADDR,
  input wire logic DEST_DONE,
  input wire logic EV_PW_PERR,
  input wire logic EV_PW_MABORT,
  input wire logic EV_DW_RETRY_TO,
  input wire logic EV_DR_RETRY_TO,
  input wire logic SEC_SERR,
  input wire logic ADDR_PERR,
  input wire logic DATA_PERR,
  input wire logic SEC_RST_ACT,
  input wire logic PRIMARY_SYSTEM_ERROR_REPORT,
  input wire logic PERR_OUT,
  input wire logic PARITY_PASS
);
  // ----------------
  // Register shadows
  // ----------------
  logic [15:0] cmd_q, bc_q, dg_q, msk_q;
  wire logic wr = PSEL & PENABLE & PREADY & PWRITE;
  wire logic sreq = PRIMARY_SYSTEM_ERROR_REPORT;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      cmd_q <= 16'h0000;
      bc_q <= 16'h0000;
      dg_q <= 16'h0000;
      msk_q <= 16'h0000;
    end else if (wr) begin
      if (PADDR == 12'h010) cmd_q <= PWDATA[15:0];
      if (PADDR == 12'h0F8) bc_q <= PWDATA[15:0];
      if (PADDR == 12'h170) dg_q <= PWDATA[15:0];
      if (PADDR == 12'h190) msk_q <= PWDATA[15:0];
    end
  end

  // ----------
  // Properties
  // ----------
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  property p_ev(logic ev, int b);
    ev && !msk_q[b] && cmd_q[8] |=> sreq;
  endproperty

  a_pw_mabort: assert property (p_ev(EV_PW_MABORT, 4))
    else $error("master abort not reported");
  a_dw_timeout: assert property (p_ev(EV_DW_RETRY_TO, 5))
    else $error("write timeout not reported");
  a_dr_timeout: assert property (p_ev(EV_DR_RETRY_TO, 6))
    else $error("read timeout not reported");
  a_pw_parity: assert property (p_ev(EV_PW_PERR, 1))
    else $error("posted parity error not reported");
  a_serr_gate: assert property (sreq |-> $past(cmd_q[8]))
    else $error("system error while disabled");
  a_sec_fwd: assert property (SEC_SERR && cmd_q[8] && bc_q[1] |=> sreq)
    else $error("secondary error not forwarded");
  a_addr_perr: assert property (ADDR_PERR && cmd_q[6] && cmd_q[8] |=> sreq)
    else $error("address parity not reported");
  a_perr_out: assert property (PERR_OUT == $past(DATA_PERR && cmd_q[6]))
    else $error("parity error output wrong");
  a_parity_sel: assert property ($stable(dg_q[14]) |-> PARITY_PASS == !dg_q[14])
    else $error("parity pass mode wrong");
  a_retry_now: assert property (TGT_REQ && !dg_q[2] |=> TGT_RESP_VLD)
    else $error("answer not immediate");
  a_sec_reset: assert property (TGT_REQ && SEC_RST_ACT && !TGT_DIR && !dg_q[2]
    |=> TGT_RESP == ($past(bc_q[5]) ? 3'h3 : 3'h0))
    else $error("secondary reset answer wrong");
  a_dest_hold: assert property (DEST_REQ && !DEST_DONE |=> DEST_REQ && $stable(DEST_ADDR))
    else $error("destination request dropped");

  c_done: cover property (TGT_RESP_VLD && TGT_RESP == 3'h2);
  c_serr: cover property (sreq);
  c_dest: cover property (DEST_REQ && DEST_DONE);
endmodule

bind pbed_bridge_err pbed_bridge_err_sva u_sva (.SYS_CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR,
  .PWDATA, .PREADY, .TGT_REQ, .TGT_DIR, .TGT_RESP_VLD, .TGT_RESP, .DEST_REQ, .DEST_ADDR,
  .DEST_DONE, .EV_PW_PERR, .EV_PW_MABORT, .EV_DW_RETRY_TO, .EV_DR_RETRY_TO, .SEC_SERR,
  .ADDR_PERR, .DATA_PERR, .SEC_RST_ACT, .PRIMARY_SYSTEM_ERROR_REPORT, .PERR_OUT, .PARITY_PASS);

`default_nettype wire

// File: verification/pbed_dest_model.sv
// Destination bus model: answers a pending access after a set latency.
// Assumes the bridge holds its request until the answer.
`default_nettype none

module pbed_dest_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic req,
  input wire logic [31:0] addr,
  input wire logic [3:0] lat,
  input wire logic abort,
  output logic done,
  output logic [31:0] rdata,
  output logic tabort
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 4'h0;
      done <= 1'b0;
      rdata <= 32'h00000000;
      tabort <= 1'b0;
    end else begin
      done <= 1'b0;
      tabort <= 1'b0;
      // Data toggles off the answer cycle, so stale data never looks valid
      rdata <= ~rdata;
      if (req && !done) begin
        if (cnt_q >= lat) begin
          cnt_q <= 4'h0;
          done <= 1'b1;
          tabort <= abort;
          rdata <= addr ^ 32'h5A5A5A5A;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end
endmodule

`default_nettype wire

// File: verification/tb.sv
// Self-checking bench of the bridge error block with a destination model.
// Assumes one APB wait state and immediate retry after reset.
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, taddr = 32'h00000000, rdat, dadr, drd;
  logic treq = 1'b0, tdir = 1'b0, rvld, dreq, ddir, ddone, dab, srst = 1'b0, abt = 1'b0, tpf = 1'b0;
  logic [3:0] tcmd = 4'h0, tbe = 4'h0, dcmd, dbe, lat = 4'h0;
  logic [2:0] resp;
  logic [5:0] ev = 6'h00;
  logic [4:0] mp = 5'h00;
  logic serr, perr, ppass, se;
  logic [31:0] rdv, seed = 32'h0000714E;
  logic [2:0] rs;
  int mismatches = 0;
  int checked = 0;
  int tn = 0;

  pbed_bridge_err #(.DISCARD_LONG_CLKS(16'h0040)) u_pbed_bridge_err (.SYS_CLK(clk), .RST(rst),
    .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .TGT_REQ(treq), .TGT_DIR(tdir), .TGT_ADDR(taddr),
    .TGT_CMD(tcmd), .TGT_BE(tbe), .TGT_PREFETCH(tpf), .TGT_RESP_VLD(rvld), .TGT_RESP(resp),
    .TGT_RDATA(rdat), .DEST_REQ(dreq), .DEST_DIR(ddir), .DEST_ADDR(dadr), .DEST_CMD(dcmd),
    .DEST_BE(dbe), .DEST_DONE(ddone), .DEST_RDATA(drd), .DEST_TABORT(dab), .EV_PW_PERR(ev[0]),
    .EV_PW_RETRY_TO(ev[1]), .EV_PW_TABORT(ev[2]), .EV_PW_MABORT(ev[3]), .EV_DW_RETRY_TO(ev[4]),
    .EV_DR_RETRY_TO(ev[5]), .SEC_SERR(mp[4]), .ADDR_PERR(mp[3]), .TABORT_RCVD(mp[2]),
    .DATA_PERR(mp[1]), .MSTR_PERR(mp[0]), .SEC_RST_ACT(srst),
    .PRIMARY_SYSTEM_ERROR_REPORT(serr), .PERR_OUT(perr), .PARITY_PASS(ppass));

  pbed_dest_model u_pbed_dest_model (.clk(clk), .rst(rst), .req(dreq), .addr(dadr), .lat(lat),
    .abort(abt), .done(ddone), .rdata(drd), .tabort(dab));

  initial begin
    forever #5 clk = ~clk;
  end

  // -----------------
  // Helpers and tasks
  // -----------------
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function logic [2:0] exp_rsp(input int k);
    return (k == 0) ? 3'h2 : ((k == 1) ? 3'h3 : 3'h4);
  endfunction

  task automatic end_sim();
    if (mismatches == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("ERROR %s exp %h got %h", nm, e, g);
      mismatches++;
    end
  endtask

  task automatic tmo(input string nm);
    $display("ERROR %s timeout exp 1 got 0", nm);
    mismatches++;
    end_sim();
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) tmo("apb");
    rdv = prdata;
    se = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic tgt(input logic [31:0] a, input logic [3:0] c, input logic [3:0] b);
    int n;
    @(posedge clk);
    treq <= 1'b1;
    taddr <= a;
    tcmd <= c;
    tbe <= b;
    @(posedge clk);
    treq <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rvld !== 1'b1 && n < 40);
    if (n >= 40) tmo("tgt");
    rs = resp;
    rdv = rdat;
    tn = n;
  endtask

  task automatic wdest(input logic [31:0] a, input logic [3:0] c, input logic [3:0] b);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (dreq !== 1'b1 && n < 40);
    chk("dest_addr", a, dadr);
    chk("dest_cmd", {28'h0, c}, {28'h0, dcmd});
    chk("dest_be", {28'h0, b}, {28'h0, dbe});
    chk("dest_dir", {31'h0, tdir}, {31'h0, ddir});
    while (ddone !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n >= 40) tmo("dest");
    @(posedge clk);
  endtask

  task automatic pulse(input logic [5:0] e, input logic [4:0] m);
    @(posedge clk);
    ev <= e;
    mp <= m;
    @(posedge clk);
    ev <= 6'h00;
    mp <= 5'h00;
  endtask

  // -------------
  // Main sequence
  // -------------
  initial begin
    logic [11:0] regs [8] = '{12'h010, 12'h018, 12'h078, 12'h0F8, 12'h170, 12'h190, 12'h1A8, 12'h200};
    logic [31:0] a;
    logic [3:0] b, c;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      apb(1'b0, regs[k], 32'h0);
      chk("reset_value", 32'h0, rdv);
    end
    chk("parity_pass", 32'h1, {31'h0, ppass});
    apb(1'b0, 12'h0FC, 32'h0);
    chk("slverr", 32'h1, {31'h0, se});
    apb(1'b1, 12'h010, 32'h00000140);
    pulse(6'h3F, 5'h00);
    apb(1'b0, 12'h1A8, 32'h0);
    chk("flags", 32'h7E, rdv);
    apb(1'b0, 12'h078, 32'h0);
    chk("sec_status", 32'h4000, rdv);
    apb(1'b1, 12'h1A8, 32'h0);
    apb(1'b0, 12'h1A8, 32'h0);
    chk("flags_keep", 32'h7E, rdv);
    apb(1'b1, 12'h1A8, 32'h7E);
    apb(1'b1, 12'h190, 32'h7E);
    pulse(6'h3F, 5'h00);
    apb(1'b0, 12'h1A8, 32'h0);
    chk("flags_masked", 32'h0, rdv);
    apb(1'b1, 12'h0F8, 32'h0002);
    pulse(6'h00, 5'h1F);
    apb(1'b0, 12'h018, 32'h0);
    chk("status", 32'h8100, rdv);
    apb(1'b1, 12'h170, 32'h4000);
    repeat (3) @(posedge clk);
    chk("parity_gen", 32'h0, {31'h0, ppass});
    apb(1'b1, 12'h170, 32'h0);
    for (int k = 0; k < 3; k++) begin
      a = rnd();
      b = a[7:4];
      c = (k == 1) ? 4'h7 : 4'h6;
      lat <= 4'(rnd() & 32'h7);
      abt <= (k != 0);
      tdir <= a[0];
      tgt(a, c, b);
      chk("first_rsp", 32'h1, {29'h0, rs});
      wdest(a, c, b);
      tgt(a, c, ~b);
      chk("mismatch_rsp", 32'h1, {29'h0, rs});
      tgt(a, c, b);
      chk("final_rsp", {29'h0, exp_rsp(k)}, {29'h0, rs});
      if (c == 4'h6) chk("read_data", a ^ 32'h5A5A5A5A, rdv);
    end
    abt <= 1'b0;
    for (int j = 0; j < 2; j++) begin
      a = rnd();
      tpf <= (j == 0);
      tgt(a, 4'h6, 4'h0);
      wdest(a, 4'h6, 4'h0);
      repeat (80) @(posedge clk);
      tgt(a, 4'h6, 4'h0);
      chk("discarded", (j == 0) ? 32'h2 : 32'h1, {29'h0, rs});
    end
    apb(1'b1, 12'h170, 32'h0004);
    tgt(rnd(), 4'h6, 4'hF);
    chk("wait_rsp", 32'h1, {29'h0, rs});
    chk("retry_wait", 32'h10, tn);
    apb(1'b1, 12'h170, 32'h0);
    srst <= 1'b1;
    tdir <= 1'b0;
    tgt(rnd(), 4'h6, 4'hF);
    chk("sec_rst_none", 32'h0, {29'h0, rs});
    apb(1'b1, 12'h0F8, 32'h0020);
    tgt(rnd(), 4'h6, 4'hF);
    chk("sec_rst_abort", 32'h3, {29'h0, rs});
    srst <= 1'b0;
    end_sim();
  end
endmodule

`default_nettype wire
